// [hw/pvi_defines.vh]
// Purpose: constants for the vector and initialisation logic of the interrupt controller
// Assumes: included by its bare name from every design file that needs it
// Notes:   definitions only, no logic
`ifndef PVI_DEFINES_VH
`define PVI_DEFINES_VH

// ************************************************************
// first initialisation word fields
// ************************************************************
`define PVI_W1_FOURTH_BIT     0
`define PVI_W1_SINGLE_BIT     1
`define PVI_W1_INTERVAL_BIT   2
`define PVI_W1_LEVEL_BIT      3
`define PVI_W1_MARK_BIT       4

// ************************************************************
// fourth initialisation word fields
// ************************************************************
`define PVI_W4_PROC_MODE_BIT  0
`define PVI_W4_AUTO_END_BIT   1
`define PVI_W4_ROLE_BIT       2
`define PVI_W4_BUFFERED_BIT   3
`define PVI_W4_NESTED_BIT     4

// ************************************************************
// acknowledge bytes and reset values
// ************************************************************
`define PVI_CALL_OPCODE       8'hCD
`define PVI_NO_REQ_LEVEL      3'h7
`define PVI_BYTE_RESET        8'h00
`define PVI_CALL_PULSES       2'h3
`define PVI_VECTOR_PULSES     2'h2

`endif

// [hw/pvi_sync.v]
// Purpose: two-stage synchroniser with edge outputs for pin inputs
// Assumes: one clock; inputs asynchronous to it
// Notes:   edges come from stage two against stage three, never from stage one
`timescale 1ns/1ps
`default_nettype none

module pvi_sync #(
  parameter W    = 8,
  parameter INIT = 0
) (
  // clock and reset
  input  wire         clk,
  input  wire         sys_rst,
  // raw pins
  input  wire [W-1:0] din,
  // synchronised level and edges
  output wire [W-1:0] dout,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  reg [W-1:0] prev_ff;

  // ************************************************************
  // synchroniser chain
  // ************************************************************
  // stage one feeds only stage two, so no logic sees a metastable value
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_ff <= INIT[W-1:0];
      sync_ff <= INIT[W-1:0];
      prev_ff <= INIT[W-1:0];
    end
    else
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // edges in the same cycle the level settles
  assign dout = sync_ff;
  assign rise = sync_ff & ~prev_ff;
  assign fall = ~sync_ff & prev_ff;

endmodule

`default_nettype wire

// [hw/pvi_controller.v]
// Purpose: acknowledge-time vector output and initialisation sequence of an
//          eight-level priority interrupt controller
// Assumes: processor strobes and pins are asynchronous to clk; all pins are
//          synchronised before use, so every strobe is seen two cycles late
// Notes:   operation words beyond the mask write, rotation and polling are absent
`timescale 1ns/1ps
`default_nettype none
`include "pvi_defines.vh"

// Notes on behaviour
// - call mode: three pulses, opcode first
// - interval four: address 7..5, level, 00
// - interval eight: address 7..6, level, 000
// - third call pulse drives high address byte
// - vector mode: two pulses, first undriven
// - first pulse freezes level, master drives cascade
// - vector byte: type bits 7..3, level
// - vector mode ignores interval and bits 10..5
// - select low, bit four set restarts init
// - init word one rearms edge sensing
// - init clears mask, reads request register
// - fourth word absent zeroes its functions
// - level flag disables edge detection
// - interval flag one means four, else eight
// - single flag skips third word
// - fourth word expected when flagged
// - master: cascade bits hand bytes to slave
// - slave drives bytes only on id match
// - buffered: pin becomes enable, role bit decides
// - nested and auto-end bits select modes
// - processor bit picks call or vector
// - acknowledge sets in-service, clears request
// - no request answers level seven, cascade idle
module pvi_controller (
  // clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // processor bus strobes
  input  wire       chip_sel_n,
  input  wire       wr_n,
  input  wire       rd_n,
  input  wire       register_select,
  input  wire       ack_strobe_n,
  // data bus, three signals of a two-way pin
  input  wire [7:0] data_in,
  output wire [7:0] data_out,
  output wire       data_oe,
  // interrupt requests and output
  input  wire [7:0] request_inputs,
  output wire       int_req,
  // cascade lines
  input  wire [2:0] cascade_id_lines_in,
  output wire [2:0] cascade_id_lines_out,
  output wire       cascade_id_lines_oe,
  // role strap in, or active-low buffer enable out
  input  wire       role_pin_or_buffer_enable_in,
  output wire       role_pin_or_buffer_enable_out,
  output wire       role_pin_or_buffer_enable_oe,
  // initialisation finished
  output wire       init_done
);

  // ************************************************************
  // states of the initialisation sequence
  // ************************************************************
  localparam ST_UNINIT = 3'b000;
  localparam ST_WAIT2  = 3'b001;
  localparam ST_WAIT3  = 3'b010;
  localparam ST_WAIT4  = 3'b011;
  localparam ST_READY  = 3'b100;

  // ************************************************************
  // pin synchronisation
  // ************************************************************
  wire [24:0] pin_raw;
  wire [24:0] pin_s;
  wire [24:0] pin_rise;
  wire [24:0] pin_fall;

  // strobes idle high, so they reset high to avoid a false edge
  assign pin_raw = {chip_sel_n, wr_n, rd_n, ack_strobe_n, register_select,
                    data_in, request_inputs, cascade_id_lines_in,
                    role_pin_or_buffer_enable_in};

  pvi_sync #(
    .W    (25),
    .INIT (25'h1E00000)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (pin_raw),
    .dout    (pin_s),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  wire       cs_s     = ~pin_s[24];
  wire       wr_rise  = pin_rise[23];
  wire       rd_s     = ~pin_s[22];
  wire       ack_s    = ~pin_s[21];
  wire       ack_fall = pin_fall[21];
  wire       ack_rise = pin_rise[21];
  wire       rs_s     = pin_s[20];
  wire [7:0] din_s    = pin_s[19:12];
  wire [7:0] req_s    = pin_s[11:4];
  wire [2:0] cas_s    = pin_s[3:1];
  wire       role_s   = pin_s[0];

  // ************************************************************
  // registers
  // ************************************************************
  reg [2:0] state_ff,   nxt_state;
  reg [7:0] w1_ff,      nxt_w1;
  reg [7:0] w2_ff,      nxt_w2;
  reg [7:0] w3_ff,      nxt_w3;
  reg [7:0] w4_ff,      nxt_w4;
  reg [7:0] irr_ff,     nxt_irr;
  reg [7:0] isr_ff,     nxt_isr;
  reg [7:0] imr_ff,     nxt_imr;
  reg [7:0] armed_ff,   nxt_armed;
  reg [1:0] pulse_ff,   nxt_pulse;
  reg [2:0] lvl_ff,     nxt_lvl;
  reg       handoff_ff, nxt_handoff;
  reg       int_ff,     nxt_int;
  reg [7:0] dout_ff,    nxt_dout;
  reg       doe_ff,     nxt_doe;
  reg [2:0] cas_ff,     nxt_cas;

  // ************************************************************
  // decoded modes
  // ************************************************************
  wire wr_take   = wr_rise & cs_s;
  wire w1_hit    = wr_take & ~rs_s & din_s[`PVI_W1_MARK_BIT];
  wire ready     = (state_ff == ST_READY);
  wire single    = w1_ff[`PVI_W1_SINGLE_BIT];
  wire level_md  = w1_ff[`PVI_W1_LEVEL_BIT];
  wire int_four  = w1_ff[`PVI_W1_INTERVAL_BIT];
  wire vec_md    = w4_ff[`PVI_W4_PROC_MODE_BIT];
  wire auto_end  = w4_ff[`PVI_W4_AUTO_END_BIT];
  wire nested    = w4_ff[`PVI_W4_NESTED_BIT];
  wire buffered  = w4_ff[`PVI_W4_BUFFERED_BIT];
  // role bit only counts when buffered; otherwise the strap decides
  wire master    = buffered ? w4_ff[`PVI_W4_ROLE_BIT] : role_s;
  wire cascaded  = ~single & master;
  wire [1:0] last_pulse = vec_md ? `PVI_VECTOR_PULSES : `PVI_CALL_PULSES;

  // lowest index, found last, wins, level zero is highest priority
  function [3:0] pick;
    input [7:0] bits;
    integer     i;
    begin
      pick = 4'h0;
      for (i = 7; i >= 0; i = i - 1)
        if (bits[i])
          pick = {1'b1, i[2:0]};
    end
  endfunction

  wire [7:0] pending  = irr_ff & ~imr_ff;
  wire [3:0] req_pick = pick(pending);
  wire [3:0] isr_pick = pick(isr_ff);

  // ************************************************************
  // vector byte formation
  // ************************************************************
  reg [7:0] vec_byte;
  reg       own_bytes;

  // choose the byte for the pulse now under way
  always @*
  begin
    own_bytes = 1'b1;
    if (cascaded)
      own_bytes = ~handoff_ff;
    else if (~single & ~master)
      own_bytes = (cas_s == w3_ff[2:0]);
    vec_byte = `PVI_BYTE_RESET;
    if (vec_md)
      vec_byte = {w2_ff[7:3], lvl_ff};
    else if (pulse_ff == 2'h1)
      vec_byte = `PVI_CALL_OPCODE;
    else if (pulse_ff == 2'h3)
      vec_byte = w2_ff;
    else if (int_four)
      vec_byte = {w1_ff[7:5], lvl_ff, 2'b00};
    else
      vec_byte = {w1_ff[7:6], lvl_ff, 3'b000};
  end

  // ************************************************************
  // initialisation sequence
  // ************************************************************
  // a restart from any state keeps a lost host from wedging the block
  always @*
  begin
    nxt_state = state_ff;
    nxt_w1    = w1_ff;
    nxt_w2    = w2_ff;
    nxt_w3    = w3_ff;
    nxt_w4    = w4_ff;
    if (w1_hit)
    begin
      nxt_w1    = din_s;
      nxt_state = ST_WAIT2;
      if (~din_s[`PVI_W1_FOURTH_BIT])
        nxt_w4 = `PVI_BYTE_RESET;
    end
    else if (wr_take & rs_s)
    begin
      case (state_ff)
        ST_WAIT2:
        begin
          nxt_w2 = din_s;
          if (~single)
            nxt_state = ST_WAIT3;
          else if (w1_ff[`PVI_W1_FOURTH_BIT])
            nxt_state = ST_WAIT4;
          else
            nxt_state = ST_READY;
        end
        ST_WAIT3:
        begin
          nxt_w3    = din_s;
          nxt_state = w1_ff[`PVI_W1_FOURTH_BIT] ? ST_WAIT4 : ST_READY;
        end
        ST_WAIT4:
        begin
          nxt_w4    = din_s;
          nxt_state = ST_READY;
        end
        default:
          nxt_state = state_ff;
      endcase
    end
  end

  // ************************************************************
  // requests, in-service and acknowledge sequence
  // ************************************************************
  reg [7:0] irr_set;
  reg [7:0] irr_clr;

  // request clears from an acknowledge lose to a fresh request edge
  always @*
  begin
    nxt_armed   = armed_ff | ~req_s;
    irr_set     = 8'h00;
    irr_clr     = 8'h00;
    nxt_isr     = isr_ff;
    nxt_imr     = imr_ff;
    nxt_pulse   = pulse_ff;
    nxt_lvl     = lvl_ff;
    nxt_handoff = handoff_ff;
    if (level_md)
    begin
      irr_set = req_s;
      irr_clr = ~req_s;
    end
    else
    begin
      irr_set   = req_s & armed_ff;
      nxt_armed = (armed_ff & ~req_s) | ~req_s;
    end
    // mask write once initialised
    if (ready & wr_take & rs_s)
      nxt_imr = din_s;
    if (ready & ack_fall)
    begin
      if (pulse_ff == 2'h0)
      begin
        // freeze the winner; nothing pending answers level seven
        nxt_lvl     = req_pick[3] ? req_pick[2:0] : `PVI_NO_REQ_LEVEL;
        nxt_handoff = req_pick[3] & cascaded & w3_ff[req_pick[2:0]];
        nxt_pulse   = 2'h1;
        if (~vec_md)
        begin
          nxt_isr[nxt_lvl] = 1'b1;
          irr_clr[nxt_lvl] = 1'b1;
        end
      end
      else
      begin
        nxt_pulse = pulse_ff + 2'h1;
        if (vec_md & (pulse_ff == 2'h1))
        begin
          nxt_isr[lvl_ff] = 1'b1;
          irr_clr[lvl_ff] = 1'b1;
        end
      end
    end
    else if (ack_rise & (pulse_ff == last_pulse))
    begin
      nxt_pulse   = 2'h0;
      nxt_handoff = 1'b0;
      if (auto_end)
        nxt_isr[lvl_ff] = 1'b0;
    end
    nxt_irr = (irr_ff & ~irr_clr) | irr_set;
    if (w1_hit)
    begin
      nxt_armed = 8'h00;
      nxt_irr   = 8'h00;
      nxt_isr   = 8'h00;
      nxt_imr   = 8'h00;
      nxt_pulse = 2'h0;
    end
  end

  // ************************************************************
  // interrupt, data bus and cascade outputs
  // ************************************************************
  // special nesting lets a slave input interrupt again at its own level
  always @*
  begin
    nxt_int = 1'b0;
    if (ready & req_pick[3] & (pulse_ff == 2'h0))
    begin
      if (~isr_pick[3] | (req_pick[2:0] < isr_pick[2:0]))
        nxt_int = 1'b1;
      else if (nested & master & (req_pick[2:0] == isr_pick[2:0]) & w3_ff[req_pick[2:0]])
        nxt_int = 1'b1;
    end
    nxt_dout = dout_ff;
    nxt_doe  = 1'b0;
    // hold off in the step cycle so a stale byte never shows as driven
    if (ack_s & (pulse_ff != 2'h0) & ~ack_fall)
    begin
      nxt_dout = vec_byte;
      if (vec_md)
        nxt_doe = (pulse_ff == 2'h2) & own_bytes;
      else if (pulse_ff == 2'h1)
        nxt_doe = single | master;
      else
        nxt_doe = own_bytes;
    end
    else if (rd_s & cs_s)
    begin
      nxt_dout = rs_s ? imr_ff : irr_ff;
      nxt_doe  = 1'b1;
    end
    nxt_cas = 3'h0;
    if (handoff_ff & (pulse_ff != 2'h0))
      nxt_cas = lvl_ff;
  end

  // ************************************************************
  // state update
  // ************************************************************
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff   <= ST_UNINIT;
      w1_ff      <= `PVI_BYTE_RESET;
      w2_ff      <= `PVI_BYTE_RESET;
      w3_ff      <= `PVI_BYTE_RESET;
      w4_ff      <= `PVI_BYTE_RESET;
      irr_ff     <= 8'h00;
      isr_ff     <= 8'h00;
      imr_ff     <= 8'h00;
      armed_ff   <= 8'h00;
      pulse_ff   <= 2'h0;
      lvl_ff     <= 3'h0;
      handoff_ff <= 1'b0;
      int_ff     <= 1'b0;
      dout_ff    <= `PVI_BYTE_RESET;
      doe_ff     <= 1'b0;
      cas_ff     <= 3'h0;
    end
    else
    begin
      state_ff   <= nxt_state;
      w1_ff      <= nxt_w1;
      w2_ff      <= nxt_w2;
      w3_ff      <= nxt_w3;
      w4_ff      <= nxt_w4;
      irr_ff     <= nxt_irr;
      isr_ff     <= nxt_isr;
      imr_ff     <= nxt_imr;
      armed_ff   <= nxt_armed;
      pulse_ff   <= nxt_pulse;
      lvl_ff     <= nxt_lvl;
      handoff_ff <= nxt_handoff;
      int_ff     <= nxt_int;
      dout_ff    <= nxt_dout;
      doe_ff     <= nxt_doe;
      cas_ff     <= nxt_cas;
    end
  end

  // ************************************************************
  // port drive
  // ************************************************************
  assign int_req                       = int_ff;
  assign data_out                      = dout_ff;
  assign data_oe                       = doe_ff;
  assign cascade_id_lines_out          = cas_ff;
  assign cascade_id_lines_oe           = ready & cascaded;
  // buffered pin turns output: low while our data buffers drive
  assign role_pin_or_buffer_enable_oe  = buffered;
  assign role_pin_or_buffer_enable_out = ~doe_ff;
  assign init_done                     = ready;

endmodule

`default_nettype wire

// [verif/pvi_host_model.sv]
// Purpose: host processor side of the controller: writes, reads, acknowledges
// Assumes: every strobe changes just after a rising clk edge
// Notes:   a released data bus shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none

module pvi_host_model (
  // clock
  input  wire        clk,
  // strobes and bus toward the controller
  output logic       chip_sel_n,
  output logic       wr_n,
  output logic       rd_n,
  output logic       register_select,
  output logic       ack_strobe_n,
  output logic [7:0] data_in,
  // answers from the controller
  input  wire  [7:0] data_out,
  input  wire        data_oe,
  input  wire  [2:0] cascade_id_lines_out
);
  // ********************
  // bus cycles
  // ********************
  initial
  begin
    chip_sel_n      = 1'b1;
    wr_n            = 1'b1;
    rd_n            = 1'b1;
    register_select = 1'b0;
    ack_strobe_n    = 1'b1;
    data_in         = 8'hA5;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // data and select stay put well around the strobe, the pins are synchronised
  task automatic put(input logic sel, input logic [7:0] val);
    @(posedge clk);
    chip_sel_n      <= 1'b0;
    register_select <= sel;
    data_in         <= val;
    hold(3);
    wr_n <= 1'b0;
    hold(4);
    wr_n <= 1'b1;
    hold(4);
    chip_sel_n <= 1'b1;
    data_in    <= ~val;
    hold(2);
  endtask

  // read cycle, sampled mid-cycle once the answer has settled
  task automatic get(input logic sel, output logic [7:0] val, output logic oe);
    @(posedge clk);
    chip_sel_n      <= 1'b0;
    register_select <= sel;
    rd_n            <= 1'b0;
    hold(5);
    @(negedge clk);
    val = data_out;
    oe  = data_oe;
    @(posedge clk);
    rd_n <= 1'b1;
    hold(5);
    chip_sel_n <= 1'b1;
    hold(1);
  endtask

  // one acknowledge pulse; the caller decides how many make a sequence
  task automatic pulse(output logic oe, output logic [7:0] val, output logic [2:0] cas);
    @(posedge clk);
    ack_strobe_n <= 1'b0;
    hold(6);
    @(negedge clk);
    oe  = data_oe;
    val = data_out;
    cas = cascade_id_lines_out;
    @(posedge clk);
    ack_strobe_n <= 1'b1;
    hold(7);
  endtask
endmodule

`default_nettype wire

// [verif/pvi_controller_asserts.sv]
// Purpose: pin-level checks of the vector and initialisation logic
// Assumes: strobes are raw pins, seen two to three clocks late inside
// Notes:   windows allow for the synchroniser delay
`timescale 1ns/1ps
`default_nettype none

module pvi_controller_asserts (
  // clock and reset
  input wire       clk,
  input wire       sys_rst,
  // processor bus
  input wire       chip_sel_n,
  input wire       wr_n,
  input wire       rd_n,
  input wire       register_select,
  input wire       ack_strobe_n,
  input wire [7:0] data_in,
  input wire [7:0] data_out,
  input wire       data_oe,
  // controller outputs
  input wire       int_req,
  input wire [2:0] cascade_id_lines_out,
  input wire       cascade_id_lines_oe,
  input wire       role_pin_or_buffer_enable_out,
  input wire       role_pin_or_buffer_enable_oe,
  input wire       init_done
);
  // ********************
  // helper logic
  // ********************
  logic [3:0] quiet_ff;

  // clocks since the last read or acknowledge strobe, saturating
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      quiet_ff <= 4'h0;
    else if (!rd_n || !ack_strobe_n)
      quiet_ff <= 4'h0;
    else if (quiet_ff != 4'hF)
      quiet_ff <= quiet_ff + 4'h1;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ********************
  // checks
  // ********************
  sequence first_word_s;
    $rose(wr_n) && !chip_sel_n && !register_select && data_in[4];
  endsequence

  sequence ready_write_s;
    init_done && $rose(wr_n) && !chip_sel_n && (register_select || !data_in[4]);
  endsequence

  restart_init_a: assert property (first_word_s |-> ##[1:8] !init_done)
    else $error("word one did not restart init");
  keep_ready_a: assert property (ready_write_s |=> init_done[*6])
    else $error("operation write left ready state");
  bus_idle_a: assert property (quiet_ff > 4'h5 |-> !data_oe)
    else $error("data driven with no strobe");
  oe_cause_a: assert property ($rose(data_oe) |-> !rd_n || !ack_strobe_n)
    else $error("data drive began outside a strobe");
  byte_hold_a: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
    else $error("byte changed while driven");
  buf_enable_a: assert property (
    role_pin_or_buffer_enable_oe |-> role_pin_or_buffer_enable_out == !data_oe)
    else $error("buffer enable not tied to drive");
  cas_ready_a: assert property (cascade_id_lines_oe |-> init_done)
    else $error("cascade driven before init");
  cas_idle_a: assert property (quiet_ff > 4'h9 |-> cascade_id_lines_out == 3'h0)
    else $error("cascade code outside acknowledge");
  cas_hold_a: assert property (
    cascade_id_lines_out != 3'h0 && $past(cascade_id_lines_out) != 3'h0
    |-> $stable(cascade_id_lines_out))
    else $error("cascade code changed in sequence");
  int_drop_a: assert property ($fell(ack_strobe_n) && int_req |-> ##[1:6] !int_req)
    else $error("interrupt held after acknowledge");
  int_ready_a: assert property ($rose(int_req) |-> init_done)
    else $error("interrupt before init done");
endmodule

bind pvi_controller pvi_controller_asserts chk_u (
  .clk(clk), .sys_rst(sys_rst), .chip_sel_n(chip_sel_n), .wr_n(wr_n), .rd_n(rd_n),
  .register_select(register_select), .ack_strobe_n(ack_strobe_n),
  .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .int_req(int_req),
  .cascade_id_lines_out(cascade_id_lines_out), .cascade_id_lines_oe(cascade_id_lines_oe),
  .role_pin_or_buffer_enable_out(role_pin_or_buffer_enable_out),
  .role_pin_or_buffer_enable_oe(role_pin_or_buffer_enable_oe), .init_done(init_done)
);

`default_nettype wire

// [verif/testbench.sv]
// Purpose: self-checking bench for init sequence and acknowledge bytes
// Assumes: host model drives strobes; bench drives requests and straps
// Notes:   two-way pins resolved here from the controller's enables
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("ERROR %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module testbench;
  // ********************
  // pins and instances
  // ********************
  logic       clk;
  logic       sys_rst;
  logic [7:0] req;
  logic [2:0] cas_in;
  logic       role_in;
  logic       oe;
  logic [7:0] d;
  logic [2:0] first_cas;
  int         n_fail;
  int         n_compared;
  wire        chip_sel_n, wr_n, rd_n, register_select, ack_strobe_n;
  wire  [7:0] host_data, data_out;
  wire        data_oe, int_req, init_done, cas_oe, role_out, role_oe;
  wire  [2:0] cas_out;

  pvi_host_model host_u (
    .clk(clk), .chip_sel_n(chip_sel_n), .wr_n(wr_n), .rd_n(rd_n),
    .register_select(register_select), .ack_strobe_n(ack_strobe_n),
    .data_in(host_data), .data_out(data_out), .data_oe(data_oe),
    .cascade_id_lines_out(cas_out)
  );

  pvi_controller dut_u (
    .clk(clk), .sys_rst(sys_rst), .chip_sel_n(chip_sel_n), .wr_n(wr_n), .rd_n(rd_n),
    .register_select(register_select), .ack_strobe_n(ack_strobe_n),
    .data_in(data_oe ? data_out : host_data), .data_out(data_out), .data_oe(data_oe),
    .request_inputs(req), .int_req(int_req),
    .cascade_id_lines_in(cas_oe ? cas_out : cas_in),
    .cascade_id_lines_out(cas_out), .cascade_id_lines_oe(cas_oe),
    .role_pin_or_buffer_enable_in(role_oe ? role_out : role_in),
    .role_pin_or_buffer_enable_out(role_out),
    .role_pin_or_buffer_enable_oe(role_oe), .init_done(init_done)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ********************
  // tasks
  // ********************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic close_out;
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // optional words follow the flags of word one
  task automatic init(input logic [7:0] w1, w2, w3, w4);
    host_u.put(1'b0, w1);
    host_u.put(1'b1, w2);
    if (!w1[1])
      host_u.put(1'b1, w3);
    if (w1[0])
      host_u.put(1'b1, w4);
    tick(3);
    `CHK(init_done, 1'b1)
  endtask

  // bounded wait; a missing interrupt ends the run
  task automatic wait_int;
    for (int i = 0; i < 20 && int_req !== 1'b1; i++)
      @(negedge clk);
    `CHK(int_req, 1'b1)
    if (int_req !== 1'b1)
      close_out;
  endtask

  // en marks the pulses that must drive; byte i sits at exp[8*i +: 8]
  task automatic acks(input int n, input logic [23:0] exp, input logic [2:0] en);
    logic [2:0] c;
    for (int i = 0; i < n; i++)
    begin
      host_u.pulse(oe, d, c);
      if (i == 0)
        first_cas = c;
      `CHK(oe, en[i])
      if (en[i])
        `CHK(d, exp[8*i +: 8])
    end
    tick(4);
  endtask

  // ********************
  // scenarios
  // ********************
  initial
  begin
    sys_rst    = 1'b1;
    req        = 8'h00;
    cas_in     = 3'h0;
    role_in    = 1'b1;
    n_fail     = 0;
    n_compared = 0;
    tick(20);
    sys_rst <= 1'b0;
    tick(5);
    host_u.put(1'b1, 8'hFF);
    host_u.put(1'b0, 8'h0F);
    `CHK(init_done, 1'b0)
    // single, call mode, interval four, address bits 101
    init(8'hB6, 8'h5A, 8'h00, 8'h00);
    `CHK(cas_oe, 1'b0)
    req <= 8'h08;
    wait_int;
    acks(3, {8'h5A, 8'hAC, 8'hCD}, 3'b111);
    host_u.get(1'b0, d, oe);
    `CHK(d, 8'h00)
    host_u.put(1'b1, 8'hFF);
    host_u.get(1'b1, d, oe);
    `CHK(d, 8'hFF)
    // request already high across word one must not fire
    req <= 8'h20;
    init(8'h92, 8'h33, 8'h00, 8'h00);
    host_u.get(1'b1, d, oe);
    `CHK(d, 8'h00)
    tick(20);
    `CHK(int_req, 1'b0)
    req <= 8'h00;
    tick(6);
    req <= 8'h20;
    wait_int;
    host_u.get(1'b0, d, oe);
    `CHK(d, 8'h20)
    acks(3, {8'h33, 8'hA8, 8'hCD}, 3'b111);
    // vector mode, buffered master, auto end, level sensing; low type bits set
    req <= 8'h40;
    init(8'hFF, 8'hCB, 8'h00, 8'h0F);
    `CHK(role_oe, 1'b1)
    wait_int;
    acks(2, {8'h00, 8'hCE, 8'h00}, 3'b010);
    wait_int;
    req <= 8'h00;
    tick(10);
    acks(2, {8'h00, 8'hCF, 8'h00}, 3'b010);
    // strapped master with a slave on input 2, fourth word absent
    init(8'h14, 8'h40, 8'h04, 8'h00);
    `CHK(role_oe, 1'b0)
    `CHK(cas_oe, 1'b1)
    req <= 8'h04;
    wait_int;
    acks(3, 24'h0000CD, 3'b001);
    `CHK(first_cas, 3'h2)
    // special nesting: the slave input may interrupt again at its own level
    req <= 8'h00;
    init(8'h15, 8'h40, 8'h04, 8'h10);
    req <= 8'h04;
    wait_int;
    acks(3, 24'h0000CD, 3'b001);
    req <= 8'h00;
    tick(6);
    req <= 8'h04;
    wait_int;
    // strapped slave with identity 5
    role_in <= 1'b0;
    req     <= 8'h00;
    cas_in  <= 3'h5;
    init(8'h14, 8'h40, 8'h05, 8'h00);
    `CHK(cas_oe, 1'b0)
    req <= 8'h02;
    wait_int;
    acks(3, {8'h40, 8'h04, 8'h00}, 3'b110);
    cas_in <= 3'h3;
    tick(10);
    acks(3, 24'h000000, 3'b000);
    close_out;
  end
endmodule

`default_nettype wire
